/* File: hdl/tcr_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH

// scratchpad byte offsets
`define TCR_SP_TEMP_LSB   3'h0
`define TCR_SP_TEMP_MSB   3'h1
`define TCR_SP_TH         3'h2
`define TCR_SP_TL         3'h3
`define TCR_SP_CFG        3'h4

// configuration byte: resolution field and fixed bits
`define TCR_CFG_RES_LSB   5
`define TCR_CFG_RES_MSB   6
`define TCR_CFG_FIXED     5'h1F

// reset values
`define TCR_TEMP_RST      16'h0550
`define TCR_TH_RST        8'h4B
`define TCR_TL_RST        8'h46
`define TCR_RES_RST       2'h3

// function commands
`define TCR_CMD_CONVERT   8'h44

// timing: longest full-resolution conversion
`define TCR_CLK_MHZ       250
`define TCR_CONV_MS       750
`define TCR_CONV_CYC      (`TCR_CONV_MS * `TCR_CLK_MHZ * 1000)

`endif

/* File: hdl/tcr_pkg.sv */
// types shared by the temperature conversion readout
package tcr_pkg;

    typedef enum logic [1:0] {
        TCR_RES_9  = 2'h0,
        TCR_RES_10 = 2'h1,
        TCR_RES_11 = 2'h2,
        TCR_RES_12 = 2'h3
    } tcr_res_t;

    typedef enum logic [0:0] {
        TCR_IDLE = 1'b0,
        TCR_CONV = 1'b1
    } tcr_state_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [7:0] data;
    } tcr_sp_wr_t;

    typedef struct packed {
        logic [15:0] temp;
        logic [7:0]  th;
        logic [7:0]  tl;
        logic [7:0]  cfg;
    } tcr_sp_view_t;

endpackage

/* File: hdl/tcr_readout.sv */
// conversion control and result formatting of the thermometer
`timescale 1ns/1ps
`include "tcr_regs.svh"

// How it works
// - resolutions 9 to 12 bits give steps of 0.5 down to 0.0625 C
// - resolution is twelve bits after power-up until configured
// - power-up lands in idle; no measurement until commanded
// - command 44h starts a measurement and conversion
// - a finished conversion stores the temperature and returns to idle
// - externally supplied: read slots return 0 while busy, 1 when done
// - temperature is a 16-bit sign-extended two's complement value
// - sign bits are 0 for positive and 1 for negative temperatures
// - lower resolutions leave bit 0, bits 1..0 or bits 2..0 undefined
// - scratchpad exposes upper, lower threshold and configuration bytes
// - thresholds and configuration are retained as nonvolatile contents; here reset reloads fixed defaults and writes are lost
// - a twelve-bit conversion completes within 750 ms
// - each device carries a unique 64-bit identification code
// - the data line is only pulled low, never driven high
// - at power-on the temperature register holds plus 85 C
module tcr_readout #(
    parameter int unsigned    CONV_CYC = `TCR_CONV_CYC,
    parameter logic [63:0]    ROM_ID   = 64'h3C5A96E1B4D2870F // arbitrary
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // decoded function commands from the slot layer
    input  wire logic                  cmd_valid,
    input  wire logic [7:0]            cmd_code,
    // scratchpad write and read view
    input  wire tcr_pkg::tcr_sp_wr_t   sp_wr,
    output tcr_pkg::tcr_sp_view_t      sp_view,
    // read slot polling and open-drain data line
    input  wire logic                  rd_slot,
    input  wire logic                  slot_end,
    output logic                       dq_out,
    output logic                       dq_oe,
    // supply strap and sensor, busy status and identification code
    input  wire logic                  line_power_storage_capacitor,
    input  wire logic [11:0]           sensor_value,
    output logic                       busy,
    output logic [63:0]                rom_code
);
    import tcr_pkg::*;

    localparam int unsigned CW = $clog2(CONV_CYC + 1);

    logic              rst_s1_q;
    logic              rst_s2_q;
    logic              rstn;
    logic              par_s1_q;
    logic              par_s2_q;
    tcr_state_t        state_q,   state_d;
    logic [CW-1:0]     cnt_q,     cnt_d;
    tcr_res_t          res_q,     res_d;
    tcr_res_t          run_res_q, run_res_d;
    logic [15:0]       temp_q,    temp_d;
    logic [7:0]        th_q,      th_d;
    logic [7:0]        tl_q,      tl_d;
    logic              oe_q,      oe_d;
    logic              start;
    logic              done;
    logic [1:0]        shift;
    logic [15:0]       result;

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rstn = rst_s2_q;

    // supply strap synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            par_s1_q <= 1'b0;
            par_s2_q <= 1'b0;
        end else begin
            par_s1_q <= line_power_storage_capacitor;
            par_s2_q <= par_s1_q;
        end
    end

    assign start = cmd_valid && (cmd_code == `TCR_CMD_CONVERT);
    assign done  = (state_q == TCR_CONV) && (cnt_q == '0);
    assign shift = 2'(TCR_RES_12 - run_res_q);
    // sign extend the 12-bit sample, zero the undefined low bits
    assign result = {{4{sensor_value[11]}}, sensor_value}
                  & (16'hFFFF << shift);

    // conversion sequencer
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        run_res_d = run_res_q;
        temp_d    = temp_q;
        case (state_q)
            TCR_IDLE: begin
                if (start) begin
                    state_d   = TCR_CONV;
                    run_res_d = res_q;
                    // duration halves per bit below twelve
                    cnt_d     = CW'((CONV_CYC >> (2'(TCR_RES_12 - res_q)))
                                    - 1);
                end
            end
            TCR_CONV: begin
                // repeated start commands are ignored here
                if (done) begin
                    state_d = TCR_IDLE;
                    temp_d  = result;
                end else begin
                    cnt_d = CW'(cnt_q - 1'b1);
                end
            end
            default: state_d = TCR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= TCR_IDLE;
            cnt_q     <= '0;
            run_res_q <= TCR_RES_12;
            temp_q    <= `TCR_TEMP_RST;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            run_res_q <= run_res_d;
            temp_q    <= temp_d;
        end
    end

    // scratchpad threshold and configuration bytes
    always_comb begin
        th_d  = th_q;
        tl_d  = tl_q;
        res_d = res_q;
        if (sp_wr.wr) begin
            case (sp_wr.addr)
                `TCR_SP_TH:  th_d = sp_wr.data;
                `TCR_SP_TL:  tl_d = sp_wr.data;
                `TCR_SP_CFG: res_d = tcr_res_t'(
                    sp_wr.data[`TCR_CFG_RES_MSB:`TCR_CFG_RES_LSB]);
                default: ;
            endcase
        end
    end

    // reset loads the fixed default threshold and configuration values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            th_q  <= `TCR_TH_RST;
            tl_q  <= `TCR_TL_RST;
            res_q <= tcr_res_t'(`TCR_RES_RST);
        end else begin
            th_q  <= th_d;
            tl_q  <= tl_d;
            res_q <= res_d;
        end
    end

    // polling answer: pull low while converting unless line powered, release when done
    always_comb begin
        oe_d = oe_q;
        if (slot_end) begin
            oe_d = 1'b0;
        end
        if (rd_slot) begin
            oe_d = (state_q == TCR_CONV) && !par_s2_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    assign dq_out   = 1'b0;
    assign dq_oe    = oe_q;
    assign busy     = (state_q == TCR_CONV);
    assign rom_code = ROM_ID;
    assign sp_view  = '{temp: temp_q, th: th_q, tl: tl_q,
                        cfg: {1'b0, res_q, `TCR_CFG_FIXED}};

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic cfg_seen_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_seen_q <= 1'b0;
        end else if (sp_wr.wr && sp_wr.addr == `TCR_SP_CFG) begin
            cfg_seen_q <= 1'b1;
        end
    end

    a_default_res: assert property (!cfg_seen_q
        |-> res_q == TCR_RES_12)
        else $error("resolution left twelve bits without a write");
    a_idle_stays: assert property (!busy && !start |=> !busy)
        else $error("conversion began without a command");
    a_start_conv: assert property (!busy && start |=> busy ##0
        cnt_q == $past(cnt_d))
        else $error("start command did not begin a conversion");
    a_done_store: assert property (done |=> !busy &&
        temp_q == $past(result))
        else $error("result not stored or idle not reached");
    a_temp_hold: assert property (busy && !done |=> $stable(temp_q))
        else $error("temperature changed during a conversion");
    a_restart_safe: assert property (busy && !done && start
        |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("repeat start disturbed the conversion");
    a_poll_answer: assert property (rd_slot && !par_s2_q
        |=> dq_oe == $past(busy))
        else $error("poll answer does not match conversion state");
    a_line_quiet: assert property (rd_slot && par_s2_q
        |=> !dq_oe)
        else $error("line-powered device pulled the line during a poll");
    a_sign_bits: assert property (temp_q[15:11] == {5{temp_q[11]}})
        else $error("sign bits of temperature disagree");
    a_low_bits: assert property (done && run_res_q == TCR_RES_9
        |=> temp_q[2:0] == 3'h0)
        else $error("undefined bits not cleared at nine bits");
    a_conv_bound: assert property (cnt_q < CW'(CONV_CYC))
        else $error("conversion count exceeds the longest time");
    a_open_drain: assert property (dq_out == 1'b0)
        else $error("data line driven high");

    c_conv_12: cover property (done && run_res_q == TCR_RES_12);
    c_conv_9: cover property (done && run_res_q == TCR_RES_9);
    c_poll_busy: cover property (rd_slot && busy ##1 dq_oe);
    c_restart: cover property (busy && start);

endmodule

/* File: tb/tcr_master_model.sv */
// bus master model: commands, read slots and the pulled-up data line
`timescale 1ns/1ps
module tcr_master_model (
    // clock
    input  wire logic clk,
    // device side
    input  wire logic dq_out,
    input  wire logic dq_oe,
    output logic      cmd_valid,
    output logic [7:0] cmd_code,
    output logic      rd_slot,
    output logic      slot_end,
    output logic      dq_line
);
    // weak pullup unless the device pulls the line low
    assign dq_line = dq_oe ? dq_out : 1'b1;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        rd_slot = 1'b0;
        slot_end = 1'b0;
    end
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        #1 cmd_valid = 1'b1;
        cmd_code = c;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        cmd_code = ~c;
    endtask
    task automatic poll(output logic b);
        @(posedge clk);
        #1 rd_slot = 1'b1;
        @(posedge clk);
        #1 rd_slot = 1'b0;
        @(posedge clk);
        #1 b = dq_line;
        slot_end = 1'b1;
        @(posedge clk);
        #1 slot_end = 1'b0;
    endtask
endmodule

/* File: tb/test_tcr_readout.sv */
// self-checking bench of the conversion readout
`timescale 1ns/1ps
`include "tcr_regs.svh"
module test_tcr_readout;
    import tcr_pkg::*;
    localparam int unsigned CYC = 64;
    localparam logic [63:0] ID = 64'h5A5A0F0F3C3C9696; // arbitrary
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic strap = 1'b0;
    logic [11:0] sensor = 12'h000;
    tcr_sp_wr_t sp_wr = '0;
    tcr_sp_view_t sp_view;
    logic dq_out, dq_oe, busy, dq_line, cmd_valid, rd_slot, slot_end;
    logic [7:0] cmd_code;
    logic [63:0] rom_code;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int run = 0;
    int last_run = 0;
    always #2 clk = ~clk;
    tcr_readout #(.CONV_CYC(CYC), .ROM_ID(ID)) i_tcr_readout (
        .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .sp_wr(sp_wr), .sp_view(sp_view),
        .rd_slot(rd_slot), .slot_end(slot_end), .dq_out(dq_out),
        .dq_oe(dq_oe), .line_power_storage_capacitor(strap),
        .sensor_value(sensor), .busy(busy), .rom_code(rom_code));
    tcr_master_model i_tcr_master_model (
        .clk(clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rd_slot(rd_slot),
        .slot_end(slot_end), .dq_line(dq_line));
    task automatic check(input string what, input logic [63:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (busy === 1'b1) run++;
        else if (run != 0) begin
            last_run = run;
            run = 0;
        end
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sp_wr = '{wr: 1'b1, addr: a, data: d};
        @(posedge clk);
        #1 sp_wr.wr = 1'b0;
        sp_wr.data = ~d;
    endtask
    // one conversion with a refused restart and polls during and after
    task automatic convert(input int r, input logic [11:0] s);
        logic b;
        int sh;
        logic [15:0] e, old;
        sh = 3 - r;
        e = {{4{s[11]}}, s} & (16'hFFFF << sh);
        old = sp_view.temp;
        sensor = s;
        i_tcr_master_model.send(`TCR_CMD_CONVERT);
        i_tcr_master_model.send(`TCR_CMD_CONVERT);
        i_tcr_master_model.poll(b);
        check("busy poll", 1'b0, b);
        check("old temp", old, sp_view.temp);
        for (int n = 0; n < 300 && busy === 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 check("conv length", CYC >> sh, last_run);
        check("temp", e, sp_view.temp);
        i_tcr_master_model.poll(b);
        check("done poll", 1'b1, b);
        $display("test convert res %0d done", r);
    endtask
    initial begin
        logic b;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        check("reset temp", 16'h0550, sp_view.temp);
        check("reset th tl", 16'h4B46, {sp_view.th, sp_view.tl});
        check("reset cfg", 8'h7F, sp_view.cfg);
        check("reset busy", 2'b00, {busy, dq_oe});
        check("id", ID, rom_code);
        // first request only once the internal reset copy has released
        repeat (2) @(posedge clk);
        i_tcr_master_model.poll(b);
        check("idle poll", 1'b1, b);
        $display("test reset done");
        convert(3, 12'h191);
        for (int i = 0; i < 3; i++) begin
            wr(3'h4, {1'b0, 2'(i), 5'h00});
            check("cfg", {1'b0, 2'(i), 5'h1F}, sp_view.cfg);
            convert(i, 12'hE6F);
        end
        wr(3'h2, 8'h19);
        wr(3'h3, 8'hF6);
        wr(3'h5, 8'hAA);
        check("th tl", 16'h19F6, {sp_view.th, sp_view.tl});
        $display("test thresholds done");
        // line power: the master would hold a strong pullup here
        strap = 1'b1;
        repeat (3) @(posedge clk);
        i_tcr_master_model.send(`TCR_CMD_CONVERT);
        i_tcr_master_model.poll(b);
        check("line power poll", 1'b1, b);
        check("line power busy", 1'b1, busy);
        $display("test line power done");
        conclude();
    end
endmodule
